// ---- core/crs_core.sv ----
// Operation
// - Index pointer is upper:lower byte concatenation
// - Reset clears upper index, keeps lower
// - Stack pointer addresses next free stack slot
// - Reset loads stack pointer with 0x00FF
// - Stack adjust adds sign-extended immediate
// - Stack low reset changes low byte only
// - PC advances per fetch, jumps load target
// - Reset loads PC from vector FFFE/FFFF
// - Flag bits 6 and 5 read one
// - Overflow flag on two's complement overflow
// - Half carry from accumulator bit 3
// - Decimal adjust corrects prior add to BCD
// - Interrupt mask set blocks maskable interrupts
// - Mask set after context push, before handler
// - No interrupt right after mask clear
// - Negative flag copies result MSB
// - Zero flag set on all-zero result
// - Carry flag on carry, borrow, shift, bit test
// - One flat 64-Kbyte space, 16-bit address
// - Test branch fetches operand, then offset
// - Register operand mode touches no memory
// - Branch offset sign-extended, added to PC
// - Core registers absent from memory space
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
module crs_core (
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [3:0]         i_avs_byteenable,
  input  wire logic [31:0]        i_avs_writedata,
  output logic [31:0]             o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // Core memory space
  output crs_pkg::crs_mem_s       o_mem,
  input  wire logic [7:0]         i_mem_rdata,
  // Maskable interrupt request
  input  wire logic               i_irq
);
  import crs_pkg::*;

  typedef enum logic [2:0] {
    S_VEC_H, S_VEC_L, S_VEC_D, S_IDLE, S_MEM, S_BOUND, S_PUSH
  } crs_state_e;

  crs_state_e  state;
  crs_cmd_s    cmd;
  crs_cmd_s    cur;
  crs_flags_s  flags;
  crs_flags_s  next_flags;
  logic [7:0]  acc;
  logic [7:0]  idx_hi;
  logic [7:0]  idx_lo;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [15:0] hx;
  logic [15:0] vec_base;
  logic [7:0]  vec_hi;
  logic [2:0]  push_cnt;
  logic        inhibit;
  logic        rd_ack;
  logic        cmd_go;
  logic        exec;
  logic        take;
  logic [7:0]  opnd;
  logic [7:0]  next_acc;
  logic [7:0]  next_hi;
  logic [7:0]  next_lo;
  logic [15:0] next_sp;
  logic [15:0] next_pc;
  logic [7:0]  br_off;

  function automatic logic [1:0] nz8(input logic [7:0] v);
    return {v[7], v == 8'h00};
  endfunction

  function automatic logic [1:0] nz16(input logic [15:0] v);
    return {v[15], v == 16'h0000};
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic logic needs_mem(input logic [7:0] op);
    return op == OP_LDA_IX || op == OP_CMP_BR_EQ ||
           op == OP_BR_BIT_SET || op == OP_BR_BIT_CLR;
  endfunction

  function automatic logic [15:0] op_len(input logic [7:0] op);
    case (op)
      OP_LDHX, OP_BR_BIT_SET, OP_BR_BIT_CLR: op_len = 16'h0003;
      OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_LDA, OP_SP_ADD,
      OP_X_DEC_BR, OP_CMP_BR_EQ, OP_BR: op_len = 16'h0002;
      default: op_len = 16'h0001;
    endcase
  endfunction

  function automatic logic br_cond(input logic [2:0] s,
                                   input crs_flags_s f);
    case (s)
      3'h0: br_cond = 1'b1;
      3'h1: br_cond = f.z;
      3'h2: br_cond = !f.z;
      3'h3: br_cond = !(f.z | (f.n ^ f.v));
      3'h4: br_cond = !(f.n ^ f.v);
      3'h5: br_cond = f.z | (f.n ^ f.v);
      3'h6: br_cond = f.n ^ f.v;
      default: br_cond = f.c;
    endcase
  endfunction

  assign hx = {idx_hi, idx_lo};
  assign cur = (state == S_IDLE) ? crs_cmd_s'(i_avs_writedata) : cmd;
  assign cmd_go = i_avs_write && i_avs_address == CRS_OFS_CMD &&
                  state == S_IDLE;
  assign exec = (cmd_go && !needs_mem(cur.op)) || state == S_MEM;
  // Memory operand arrives one cycle after the read strobe
  assign opnd = (state == S_MEM) ? i_mem_rdata : cur.opa;

  // Bus stalls: reads take one wait cycle, commands wait until idle
  assign o_avs_waitrequest = (i_avs_read && !rd_ack) ||
    (i_avs_write && state != S_IDLE &&
     (i_avs_address == CRS_OFS_CMD || i_avs_address == CRS_OFS_ACC));

  always_comb begin
    logic [8:0] s9;
    logic [7:0] r;
    logic [7:0] corr;
    s9 = 9'h000;
    r = 8'h00;
    corr = 8'h00;
    next_flags = flags;
    next_acc = acc;
    next_hi = idx_hi;
    next_lo = idx_lo;
    next_sp = sp;
    take = 1'b0;
    br_off = cur.opa;
    case (cur.op)
      OP_ADD, OP_ADC: begin
        s9 = {1'b0, acc} + {1'b0, opnd} +
             {8'h00, cur.op == OP_ADC && flags.c};
        r = s9[7:0];
        next_flags.h = acc[4] ^ opnd[4] ^ r[4];
        next_flags.v = acc[7] == opnd[7] && r[7] != acc[7];
        next_flags.c = s9[8];
        {next_flags.n, next_flags.z} = nz8(r);
        next_acc = r;
      end
      OP_SUB: begin
        s9 = {1'b0, acc} - {1'b0, opnd};
        r = s9[7:0];
        next_flags.v = acc[7] != opnd[7] && r[7] != acc[7];
        next_flags.c = s9[8];
        {next_flags.n, next_flags.z} = nz8(r);
        next_acc = r;
      end
      OP_AND, OP_LDA, OP_LDA_IX: begin
        r = (cur.op == OP_AND) ? (acc & opnd) : opnd;
        next_flags.v = 1'b0;
        {next_flags.n, next_flags.z} = nz8(r);
        next_acc = r;
      end
      OP_STA_IX: begin
        next_flags.v = 1'b0;
        {next_flags.n, next_flags.z} = nz8(acc);
      end
      OP_DEC_ADJ: begin
        // Correction per nibble from half carry and carry
        corr[3:0] = (flags.h || acc[3:0] > 4'h9) ? 4'h6 : 4'h0;
        corr[7:4] = (flags.c || acc > 8'h99) ? 4'h6 : 4'h0;
        r = acc + corr;
        next_flags.c = flags.c || acc > 8'h99;
        {next_flags.n, next_flags.z} = nz8(r);
        next_acc = r;
      end
      OP_ASLA: begin
        r = {acc[6:0], 1'b0};
        next_flags.c = acc[7];
        next_flags.v = r[7] ^ acc[7];
        {next_flags.n, next_flags.z} = nz8(r);
        next_acc = r;
      end
      OP_SP_ADD: next_sp = sp + sext(opnd);
      OP_SP_LOW_RST: next_sp = {sp[15:8], CRS_SP_LOW_RST};
      OP_CLR_MASK: next_flags.i = 1'b0;
      OP_SET_MASK: next_flags.i = 1'b1;
      OP_A_TO_FLAGS: begin
        next_flags = {acc[CRS_FLAG_V], acc[CRS_FLAG_H], acc[CRS_FLAG_I],
                      acc[CRS_FLAG_N], acc[CRS_FLAG_Z], acc[CRS_FLAG_C]};
      end
      OP_FLAGS_TO_A: next_acc = crs_flags_pack(flags);
      OP_INCX: begin
        next_lo = idx_lo + 8'h01;
        next_flags.v = next_lo == 8'h80;
        {next_flags.n, next_flags.z} = nz8(next_lo);
      end
      OP_X_DEC_BR: begin
        next_lo = idx_lo - 8'h01;
        take = next_lo != 8'h00;
      end
      OP_LDHX: begin
        {next_hi, next_lo} = {cur.opa, cur.opb};
        next_flags.v = 1'b0;
        {next_flags.n, next_flags.z} = nz16({cur.opa, cur.opb});
      end
      OP_CMP_BR_EQ: begin
        // Operand came from the index pointer; pointer then steps
        take = acc == opnd;
        {next_hi, next_lo} = hx + 16'h0001;
      end
      OP_BR_BIT_SET, OP_BR_BIT_CLR: begin
        next_flags.c = opnd[cur.sel];
        take = opnd[cur.sel] == (cur.op == OP_BR_BIT_SET);
        br_off = cur.opb;
      end
      OP_BR: take = br_cond(cur.sel, flags);
      default: next_flags = flags;
    endcase
    next_pc = pc + op_len(cur.op) + (take ? sext(br_off) : 16'h0000);
  end

  always_comb begin
    o_mem = '0;
    case (state)
      S_VEC_H: begin
        o_mem.rd = 1'b1;
        o_mem.addr = vec_base;
      end
      S_VEC_L: begin
        o_mem.rd = 1'b1;
        o_mem.addr = vec_base + 16'h0001;
      end
      S_IDLE: begin
        if (cmd_go && needs_mem(cur.op)) begin
          o_mem.rd = 1'b1;
          o_mem.addr = (cur.op == OP_BR_BIT_SET ||
                        cur.op == OP_BR_BIT_CLR) ? {8'h00, cur.opa} : hx;
        end else if (cmd_go && cur.op == OP_STA_IX) begin
          o_mem.wr = 1'b1;
          o_mem.addr = hx;
          o_mem.wdata = acc;
        end
      end
      S_PUSH: begin
        o_mem.wr = 1'b1;
        o_mem.addr = sp;
        case (push_cnt)
          3'h0: o_mem.wdata = pc[7:0];
          3'h1: o_mem.wdata = pc[15:8];
          3'h2: o_mem.wdata = idx_lo;
          3'h3: o_mem.wdata = acc;
          default: o_mem.wdata = crs_flags_pack(flags);
        endcase
      end
      default: o_mem = '0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state <= S_VEC_H;
      vec_base <= CRS_RST_VEC;
      vec_hi <= 8'h00;
      push_cnt <= 3'h0;
      inhibit <= 1'b0;
      cmd <= '0;
    end else begin
      case (state)
        S_VEC_H: state <= S_VEC_L;
        S_VEC_L: begin
          vec_hi <= i_mem_rdata;
          state <= S_VEC_D;
        end
        S_VEC_D: state <= S_IDLE;
        S_IDLE: begin
          if (cmd_go) begin
            cmd <= cur;
            state <= needs_mem(cur.op) ? S_MEM : S_BOUND;
            inhibit <= cur.op == OP_CLR_MASK ||
                       cur.op == OP_A_TO_FLAGS;
          end
        end
        S_MEM: state <= S_BOUND;
        S_BOUND: begin
          inhibit <= 1'b0;
          if (i_irq && !flags.i && !inhibit) begin
            state <= S_PUSH;
            push_cnt <= 3'h0;
          end else begin
            state <= S_IDLE;
          end
        end
        S_PUSH: begin
          if (push_cnt == CRS_PUSH_LAST) begin
            vec_base <= CRS_IRQ_VEC;
            state <= S_VEC_H;
          end else begin
            push_cnt <= push_cnt + 3'h1;
          end
        end
        default: state <= S_VEC_H;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pc <= CRS_PC_RST;
    end else if (state == S_VEC_D) begin
      pc <= {vec_hi, i_mem_rdata};
    end else if (exec) begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sp <= CRS_SP_RST;
    end else if (exec) begin
      sp <= next_sp;
    end else if (state == S_PUSH) begin
      sp <= sp - 16'h0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      flags <= CRS_FLAGS_RST;
    end else if (exec) begin
      flags <= next_flags;
    end else if (state == S_PUSH && push_cnt == CRS_PUSH_LAST) begin
      flags.i <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      idx_hi <= CRS_IDX_HI_RST;
    end else if (exec) begin
      idx_hi <= next_hi;
    end
  end

  // Lower index and accumulator deliberately survive reset
  always_ff @(posedge i_mclk) begin
    if (exec) begin
      idx_lo <= next_lo;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (exec) begin
      acc <= next_acc;
    end else if (i_avs_write && i_avs_address == CRS_OFS_ACC &&
                 state == S_IDLE && i_avs_byteenable[0]) begin
      acc <= i_avs_writedata[7:0];
    end
  end

  // Debug readback port only; the memory space never sees these
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rd_ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= i_avs_read && !rd_ack;
      if (i_avs_read && !rd_ack) begin
        case (i_avs_address)
          CRS_OFS_CMD: o_avs_readdata <= cmd;
          CRS_OFS_STAT: o_avs_readdata <= {29'h0, i_irq, inhibit,
                                           state != S_IDLE};
          CRS_OFS_FLAGS: o_avs_readdata <= {24'h00_0000,
                                            crs_flags_pack(flags)};
          CRS_OFS_INDEX: o_avs_readdata <= {16'h0000, hx};
          CRS_OFS_STACK: o_avs_readdata <= {16'h0000, sp};
          CRS_OFS_PC: o_avs_readdata <= {16'h0000, pc};
          CRS_OFS_ACC: o_avs_readdata <= {24'h00_0000, acc};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_ones;
    i_avs_read && !rd_ack && i_avs_address == CRS_OFS_FLAGS
      |=> o_avs_readdata[6:5] == 2'b11;
  endproperty
  a_ones: assert property (p_ones)
    else $error("flag bits 6:5 not one");

  property p_sp_rst;
    $rose(i_rst_b) |-> sp == 16'h00ff && idx_hi == 8'h00;
  endproperty
  a_sp_rst: assert property (p_sp_rst)
    else $error("sp or upper index wrong after reset");

  property p_sp_low;
    exec && cur.op == OP_SP_LOW_RST
      |=> sp == {$past(sp[15:8]), 8'hff};
  endproperty
  a_sp_low: assert property (p_sp_low)
    else $error("stack low reset touched high byte");

  property p_sp_add;
    exec && cur.op == OP_SP_ADD
      |=> sp == $past(sp) + {{8{$past(opnd[7])}}, $past(opnd)};
  endproperty
  a_sp_add: assert property (p_sp_add)
    else $error("stack adjust wrong");

  property p_vec;
    state == S_VEC_D |=> pc == {$past(vec_hi), $past(i_mem_rdata)};
  endproperty
  a_vec: assert property (p_vec)
    else $error("pc not loaded from vector");

  property p_mask_late;
    state == S_BOUND && !flags.i ##1 state == S_PUSH
      |-> !flags.i [*5] ##1 flags.i;
  endproperty
  a_mask_late: assert property (p_mask_late)
    else $error("mask not set right after push");

  property p_masked;
    state == S_BOUND && flags.i |=> state == S_IDLE;
  endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt taken while masked");

  property p_inhibit;
    cmd_go && cur.op == OP_CLR_MASK |=> state == S_BOUND ##1 state == S_IDLE;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("interrupt right after mask clear");

  property p_ix_addr;
    cmd_go && cur.op == OP_LDA_IX |-> o_mem.rd && o_mem.addr == hx;
  endproperty
  a_ix_addr: assert property (p_ix_addr)
    else $error("indexed access not at index pointer");

  property p_zero;
    exec && (cur.op == OP_LDA || cur.op == OP_LDA_IX)
      |=> flags.z == ($past(opnd) == 8'h00) && flags.n == $past(opnd[7]);
  endproperty
  a_zero: assert property (p_zero)
    else $error("load flags wrong");
endmodule // crs_core
`default_nettype wire

// ---- inc/crs_pkg.sv ----
`default_nettype none
package crs_pkg;
  // Avalon byte offsets
  localparam logic [4:0] CRS_OFS_CMD   = 5'h00;
  localparam logic [4:0] CRS_OFS_STAT  = 5'h04;
  localparam logic [4:0] CRS_OFS_FLAGS = 5'h08;
  localparam logic [4:0] CRS_OFS_INDEX = 5'h0c;
  localparam logic [4:0] CRS_OFS_STACK = 5'h10;
  localparam logic [4:0] CRS_OFS_PC    = 5'h14;
  localparam logic [4:0] CRS_OFS_ACC   = 5'h18;

  // Vectors and reset values
  localparam logic [15:0] CRS_RST_VEC    = 16'hfffe;
  localparam logic [15:0] CRS_IRQ_VEC    = 16'hfffa;
  localparam logic [15:0] CRS_SP_RST     = 16'h00ff;
  localparam logic [15:0] CRS_PC_RST     = 16'h0000;
  localparam logic [7:0]  CRS_IDX_HI_RST = 8'h00;
  localparam logic [7:0]  CRS_SP_LOW_RST = 8'hff;
  localparam logic [2:0]  CRS_PUSH_LAST  = 3'h4;

  // Field positions of condition_flags
  localparam int CRS_FLAG_V = 7;
  localparam int CRS_FLAG_O1 = 6;
  localparam int CRS_FLAG_O0 = 5;
  localparam int CRS_FLAG_H = 4;
  localparam int CRS_FLAG_I = 3;
  localparam int CRS_FLAG_N = 2;
  localparam int CRS_FLAG_Z = 1;
  localparam int CRS_FLAG_C = 0;

  // Command opcodes
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_ADD        = 8'h01;
  localparam logic [7:0] OP_ADC        = 8'h02;
  localparam logic [7:0] OP_SUB        = 8'h03;
  localparam logic [7:0] OP_AND        = 8'h04;
  localparam logic [7:0] OP_LDA        = 8'h05;
  localparam logic [7:0] OP_LDA_IX     = 8'h06;
  localparam logic [7:0] OP_STA_IX     = 8'h07;
  localparam logic [7:0] OP_DEC_ADJ    = 8'h08;
  localparam logic [7:0] OP_ASLA       = 8'h09;
  localparam logic [7:0] OP_SP_ADD     = 8'h0a;
  localparam logic [7:0] OP_SP_LOW_RST = 8'h0b;
  localparam logic [7:0] OP_CLR_MASK   = 8'h0c;
  localparam logic [7:0] OP_SET_MASK   = 8'h0d;
  localparam logic [7:0] OP_A_TO_FLAGS = 8'h0e;
  localparam logic [7:0] OP_FLAGS_TO_A = 8'h0f;
  localparam logic [7:0] OP_INCX       = 8'h10;
  localparam logic [7:0] OP_X_DEC_BR   = 8'h11;
  localparam logic [7:0] OP_LDHX       = 8'h12;
  localparam logic [7:0] OP_CMP_BR_EQ  = 8'h13;
  localparam logic [7:0] OP_BR_BIT_SET = 8'h14;
  localparam logic [7:0] OP_BR_BIT_CLR = 8'h15;
  localparam logic [7:0] OP_BR         = 8'h16;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] sel;
    logic [7:0] opb;
    logic [7:0] opa;
    logic [7:0] op;
  } crs_cmd_s;

  typedef struct packed {
    logic v;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } crs_flags_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } crs_mem_s;

  localparam crs_flags_s CRS_FLAGS_RST = 6'h08;

  function automatic logic [7:0] crs_flags_pack(input crs_flags_s f);
    logic [7:0] r;
    r = 8'h00;
    r[CRS_FLAG_V] = f.v;
    r[CRS_FLAG_O1] = 1'b1;
    r[CRS_FLAG_O0] = 1'b1;
    r[CRS_FLAG_H] = f.h;
    r[CRS_FLAG_I] = f.i;
    r[CRS_FLAG_N] = f.n;
    r[CRS_FLAG_Z] = f.z;
    r[CRS_FLAG_C] = f.c;
    return r;
  endfunction
endpackage : crs_pkg
`default_nettype wire

// ---- dv/tb_crs_core.sv ----
`default_nettype none
module tb_crs_core;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  // Design ports
  logic        i_mclk;
  logic        i_rst_b;
  logic [4:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  crs_mem_s    o_mem;
  logic [7:0]  i_mem_rdata;
  logic        i_irq;
  // Bench state
  logic [7:0]  mem [0:65535];
  logic        wait_seen;
  logic [31:0] rdata_seen;
  int          bad_count;
  int          total_checks;
  int          m_acc, m_fl, m_pc, m_sp;

  crs_core dut (
    .i_mclk           (i_mclk),
    .i_rst_b          (i_rst_b),
    .i_avs_address    (i_avs_address),
    .i_avs_read       (i_avs_read),
    .i_avs_write      (i_avs_write),
    .i_avs_byteenable (4'h1),
    .i_avs_writedata  (i_avs_writedata),
    .o_avs_readdata   (o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_mem            (o_mem),
    .i_mem_rdata      (i_mem_rdata),
    .i_irq            (i_irq)
  );

  initial i_mclk = 1'b0;
  always #20 i_mclk = ~i_mclk;

  // Settled values seen before the next rising edge
  always @(negedge i_mclk) begin
    wait_seen = o_avs_waitrequest;
    rdata_seen = o_avs_readdata;
  end

  // Memory answers one cycle after a read; idle data toggles
  always @(posedge i_mclk) begin
    if (o_mem.rd === 1'b1) begin
      i_mem_rdata <= mem[o_mem.addr];
    end else begin
      i_mem_rdata <= ~i_mem_rdata;
    end
    if (o_mem.wr === 1'b1) begin
      mem[o_mem.addr] <= o_mem.wdata;
    end
  end

  function automatic int sx(input int o);
    return o - ((o & 'h80) << 1);
  endfunction

  function automatic logic [7:0] bcd(input int x);
    return 8'(((x / 10) << 4) | (x % 10));
  endfunction

  function automatic bit taken(input int s, input int f);
    bit z, n, v;
    z = f[1];
    n = f[2];
    v = f[7];
    case (s)
      0: return 1'b1;
      1: return z;
      2: return !z;
      3: return !(z | (n ^ v));
      4: return !(n ^ v);
      5: return z | (n ^ v);
      6: return n ^ v;
      default: return f[0];
    endcase
  endfunction

  task automatic alu(input int t, input int b);
    int a, r, ci, v, h, c;
    a = m_acc;
    ci = (t == 2) ? (m_fl & 1) : 0;
    r = (t == 3) ? a - b : a + b + ci;
    if (t == 3) begin
      v = (a ^ b) & (a ^ r) & 'h80;
      h = m_fl & 'h10;
      c = (b > a);
    end else begin
      v = ~(a ^ b) & (a ^ r) & 'h80;
      h = (((a & 15) + (b & 15) + ci) > 15) ? 'h10 : 0;
      c = (r > 255);
    end
    m_acc = r & 'hff;
    m_fl = (v ? 'h80 : 0) | 'h60 | h | (m_fl & 8) | ((m_acc >> 5) & 4)
         | ((m_acc == 0) ? 2 : 0) | c;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic av(input bit w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_mclk);
      n++;
    end while (wait_seen !== 1'b0 && n < 50);
    q = rdata_seen;
    if (n >= 50) begin
      chk("waitrequest", 0, 1);
    end
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    av(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask

  task automatic idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      av(1'b0, CRS_OFS_STAT, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) begin
      chk("idle", 0, 1);
    end
  endtask

  task automatic cmd(input logic [7:0] op, a, b, input int s);
    logic [31:0] q;
    av(1'b1, CRS_OFS_CMD, {5'h00, 3'(s), b, a, op}, q);
    idle();
  endtask

  task automatic acc_wr(input int v);
    logic [31:0] q;
    av(1'b1, CRS_OFS_ACC, 32'(v), q);
    m_acc = v;
  endtask

  task automatic rst();
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    m_pc = {mem[16'hfffe], mem[16'hffff]};
    m_sp = 'hff;
    m_fl = 'h68;
    idle();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge i_mclk);
    chk("watchdog", 0, 1);
    stop_test();
  end

  initial begin
    logic [31:0] q;
    int v, a, b, t, o, e, k;
    int adj [4];
    i_rst_b = 1'b0;
    i_avs_address = 5'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0000_0000;
    i_irq = 1'b0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(55));
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'($urandom);
    end
    rst();
    rdc(CRS_OFS_PC, m_pc, "pc_reset");
    rdc(CRS_OFS_STACK, m_sp, "sp_reset");
    av(1'b0, CRS_OFS_INDEX, 32'h0000_0000, q);
    chk("index_hi_reset", 0, q[15:8]);
    rdc(CRS_OFS_FLAGS, m_fl, "flags_reset");
    $display("test reset done");
    // Every branch condition over random flag patterns
    for (int i = 0; i < 16; i++) begin
      v = ($urandom & 'hff) | 'h08;
      acc_wr(v);
      cmd(OP_A_TO_FLAGS, 8'h00, 8'h00, 0);
      m_fl = v | 'h60;
      rdc(CRS_OFS_FLAGS, m_fl, "flags_fixed");
      av(1'b0, CRS_OFS_PC, 32'h0000_0000, q);
      o = (i == 0) ? 0 : ($urandom & 'hff);
      cmd(OP_BR, 8'(o), 8'h00, i % 8);
      e = q + 2 + (taken(i % 8, m_fl) ? sx(o) : 0);
      rdc(CRS_OFS_PC, e & 'hffff, "pc_branch");
    end
    $display("test branch done");
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 'h80 : ($urandom & 'hff);
      b = (i == 0) ? 'h80 : ($urandom & 'hff);
      t = 1 + i % 3;
      acc_wr(a);
      cmd(8'(t), 8'(b), 8'h00, 0);
      alu(t, b);
      rdc(CRS_OFS_ACC, m_acc, "acc_alu");
      rdc(CRS_OFS_FLAGS, m_fl, "flags_alu");
    end
    $display("test arithmetic done");
    for (int i = 0; i < 6; i++) begin
      a = $urandom % 100;
      b = $urandom % 100;
      acc_wr(bcd(a));
      cmd(OP_ADD, bcd(b), 8'h00, 0);
      cmd(OP_DEC_ADJ, 8'h00, 8'h00, 0);
      rdc(CRS_OFS_ACC, bcd((a + b) % 100), "acc_decimal");
      av(1'b0, CRS_OFS_FLAGS, 32'h0000_0000, q);
      chk("carry_decimal", (a + b) > 99, q[0]);
    end
    $display("test decimal done");
    adj = '{'h7f, 'h7f, 'h80, $urandom & 'hff};
    foreach (adj[i]) begin
      cmd(OP_SP_ADD, 8'(adj[i]), 8'h00, 0);
      m_sp = (m_sp + sx(adj[i])) & 'hffff;
      rdc(CRS_OFS_STACK, m_sp, "sp_adjust");
    end
    cmd(OP_SP_LOW_RST, 8'h00, 8'h00, 0);
    m_sp = m_sp | 'hff;
    rdc(CRS_OFS_STACK, m_sp, "sp_low_reset");
    $display("test stack done");
    // Shift, flag copy, bit tests and pointer branches
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 'hff;
      acc_wr(v);
      cmd(OP_A_TO_FLAGS, 8'h00, 8'h00, 0);
      a = $urandom & 'hff;
      acc_wr(a);
      cmd(OP_ASLA, 8'h00, 8'h00, 0);
      m_acc = (a << 1) & 'hff;
      m_fl = (v & 'h18) | 'h60 | ((a ^ m_acc) & 'h80) | ((m_acc >> 5) & 4)
           | ((m_acc == 0) ? 2 : 0) | (a >> 7);
      rdc(CRS_OFS_ACC, m_acc, "acc_shift");
      cmd(OP_FLAGS_TO_A, 8'h00, 8'h00, 0);
      rdc(CRS_OFS_ACC, m_fl, "acc_flags_copy");
      b = $urandom & 'hff;
      o = $urandom & 'hff;
      t = $urandom % 8;
      k = (mem[b] >> t) & 1;
      av(1'b0, CRS_OFS_PC, 32'h0000_0000, q);
      cmd((i & 1) ? OP_BR_BIT_SET : OP_BR_BIT_CLR, 8'(b), 8'(o), t);
      e = q + 3 + ((k == (i & 1)) ? sx(o) : 0);
      rdc(CRS_OFS_PC, e & 'hffff, "pc_bit_branch");
      av(1'b0, CRS_OFS_FLAGS, 32'h0000_0000, q);
      chk("carry_bit_test", k, q[0]);
      a = $urandom & 'hffff;
      cmd(OP_LDHX, 8'(a >> 8), 8'(a), 0);
      acc_wr((i < 2) ? mem[a] : v);
      av(1'b0, CRS_OFS_PC, 32'h0000_0000, q);
      cmd(OP_CMP_BR_EQ, 8'(o), 8'h00, 0);
      e = q + 2 + ((m_acc == mem[a]) ? sx(o) : 0);
      rdc(CRS_OFS_PC, e & 'hffff, "pc_compare_branch");
      rdc(CRS_OFS_INDEX, (a + 1) & 'hffff, "index_step");
      av(1'b0, CRS_OFS_PC, 32'h0000_0000, q);
      cmd(OP_X_DEC_BR, 8'(o), 8'h00, 0);
      e = q + 2 + ((((a + 1) & 'hff) != 1) ? sx(o) : 0);
      rdc(CRS_OFS_PC, e & 'hffff, "pc_count_branch");
      e = ((a + 1) & 'hff00) | (a & 'hff);
      rdc(CRS_OFS_INDEX, e, "index_count");
      cmd(OP_INCX, 8'h00, 8'h00, 0);
      rdc(CRS_OFS_INDEX, (a + 1) & 'hffff, "index_inc");
    end
    cmd(OP_LDA, 8'(v), 8'h00, 0);
    cmd(OP_AND, 8'(o), 8'h00, 0);
    rdc(CRS_OFS_ACC, v & o, "acc_and");
    cmd(OP_SET_MASK, 8'h00, 8'h00, 0);
    av(1'b0, CRS_OFS_FLAGS, 32'h0000_0000, q);
    chk("mask_set", 1, q[3]);
    $display("test bit branch done");
    a = $urandom & 'hffff;
    b = a ^ 'h8421;
    v = $urandom & 'hff;
    cmd(OP_LDHX, 8'(a >> 8), 8'(a), 0);
    rdc(CRS_OFS_INDEX, a, "index_pair");
    acc_wr(v);
    cmd(OP_STA_IX, 8'h00, 8'h00, 0);
    chk("mem_store", v, mem[a]);
    mem[b] = 8'h80;
    cmd(OP_LDHX, 8'(b >> 8), 8'(b), 0);
    cmd(OP_LDA_IX, 8'h00, 8'h00, 0);
    rdc(CRS_OFS_ACC, 'h80, "acc_load");
    av(1'b0, CRS_OFS_FLAGS, 32'h0000_0000, q);
    chk("flags_load", 'h04, q & 'h06);
    $display("test index done");
    acc_wr('h2b);
    cmd(OP_A_TO_FLAGS, 8'h00, 8'h00, 0);
    i_irq <= 1'b1;
    cmd(OP_NOP, 8'h00, 8'h00, 0);
    rdc(CRS_OFS_STACK, m_sp, "sp_masked");
    cmd(OP_CLR_MASK, 8'h00, 8'h00, 0);
    rdc(CRS_OFS_STACK, m_sp, "sp_inhibit");
    cmd(OP_NOP, 8'h00, 8'h00, 0);
    i_irq <= 1'b0;
    rdc(CRS_OFS_STACK, m_sp - 5, "sp_push");
    av(1'b0, CRS_OFS_FLAGS, 32'h0000_0000, q);
    chk("mask_after_push", 1, q[3]);
    e = {mem[16'hfffa], mem[16'hfffb]};
    rdc(CRS_OFS_PC, e, "pc_vector");
    chk("push_index", b & 'hff, mem[m_sp - 2]);
    chk("push_acc", 'h2b, mem[m_sp - 3]);
    chk("push_flags", 'h63, mem[m_sp - 4]);
    $display("test interrupt done");
    rdc(5'h1c, 0, "unmapped");
    av(1'b1, CRS_OFS_PC, 32'h0000_5555, q);
    rdc(CRS_OFS_PC, e, "pc_read_only");
    $display("test bus done");
    mem[16'hfffe] = 8'h9c;
    rst();
    rdc(CRS_OFS_INDEX, b & 'hff, "index_keep");
    rdc(CRS_OFS_STACK, 'hff, "sp_rereset");
    rdc(CRS_OFS_PC, m_pc, "pc_rereset");
    $display("test second reset done");
    stop_test();
  end
endmodule // tb_crs_core
`default_nettype wire
